/* File: hdl/aims_scan_step.sv */
// Purpose: Finds the next included input above a given index, wrapping to the lowest
// Assumes: Index 15 means no current input
// Notes:   found is low when no input is included
`default_nettype none

module aims_scan_step (
    // Inclusion mask and current index
    input wire logic [8:0] mask,
    input wire logic [3:0] cur,
    // Next index
    output logic [3:0] nxt,
    output logic found
);

    always_comb begin
        nxt = cur;
        found = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            if (mask[i] && (4'(i) > cur)) begin
                nxt = 4'(i);
                found = 1'b1;
            end
        end
        if (!found) begin
            for (int i = 8; i >= 0; i--) begin
                if (mask[i]) begin
                    nxt = 4'(i);
                    found = 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: hdl/aims_top.sv */
// Purpose: AHB-Lite register block that steers the ADC analog input multiplexer and port buffers
// Assumes: Single word transfers; conv_done pulses once per finished conversion
// Notes:   Selection outputs change at the same edge at which a write lands
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`include "aims_consts.svh"
`default_nettype none

module aims_top #(
    parameter bit large_part = 1'b1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter sequencing
    input wire logic conv_done,
    // Analog multiplexer selects
    output logic [3:0] ch0_pos_sel,
    output logic ch0_pos_lowref,
    output logic ch0_neg_an1,
    output logic ch0_reserved,
    output logic trio_pos_hi,
    output logic trio_neg_an678,
    output logic trio_reserved,
    output logic slot_b,
    // Port pin control
    output logic [8:0] port_read_en,
    output logic [8:0] mux_ground
);

    aims_pkg::aims_state_s st;
    aims_pkg::aims_state_s next_st;
    logic [3:0] step_cur;
    logic [3:0] step_nxt;
    logic step_found;
    logic [8:0] pin_exists;
    logic [4:0] max_code;

    // ----------------------------------------------------------------
    // Part size
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            pin_exists[i] = 4'(i) < (large_part ? `AIMS_PINS_LARGE : `AIMS_PINS_SMALL);
        end
        max_code = large_part ? `AIMS_MAXC_LARGE : `AIMS_MAXC_SMALL;
    end

    // ----------------------------------------------------------------
    // Scan sequencer
    // ----------------------------------------------------------------
    assign step_cur = st.ctrl[`AIMS_CTL_SCAN] ? st.scan_ptr : `AIMS_PTR_NONE;

    aims_scan_step u_step (
        .mask(st.scan[8:0]),
        .cur(step_cur),
        .nxt(step_nxt),
        .found(step_found)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [4:0] pos;
        logic [1:0] tneg;
        logic scanning;
        next_st = st;
        pos = 5'h00;
        tneg = 2'h0;
        scanning = 1'b0;
        // Data phase of a write lands in the addressed register
        if (st.ph_wr) begin
            case (st.ph_addr)
                `AIMS_OFS_CH123: next_st.ch123 = hwdata[15:0] & `AIMS_MSK_CH123;
                `AIMS_OFS_CH0: next_st.ch0 = hwdata[15:0] & `AIMS_MSK_CH0;
                `AIMS_OFS_SCAN: next_st.scan = hwdata[15:0] & `AIMS_MSK_NINE;
                `AIMS_OFS_PORT: next_st.port_cfg = hwdata[15:0] & `AIMS_MSK_NINE;
                `AIMS_OFS_CTRL: next_st.ctrl = hwdata[15:0] & `AIMS_MSK_CTRL;
                default: ;
            endcase
        end
        // Sample slot advances per conversion in alternate mode, scan pointer per slot A conversion or when its input is excluded
        if (!st.ctrl[`AIMS_CTL_ALT]) begin
            next_st.slot_b = 1'b0;
        end else if (conv_done) begin
            next_st.slot_b = ~st.slot_b;
        end
        if (!st.ctrl[`AIMS_CTL_SCAN]) begin
            next_st.scan_ptr = step_found ? step_nxt : 4'h0;
        end else if (conv_done && !st.slot_b && step_found) begin
            next_st.scan_ptr = step_nxt;
        end else if (!st.scan[st.scan_ptr] && step_found) begin
            next_st.scan_ptr = step_nxt;
        end
        // Address phase
        next_st.ph_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_st.ph_wr = hwrite;
            next_st.ph_addr = haddr[4:0];
            if (!hwrite) begin
                case (haddr[4:0])
                    `AIMS_OFS_CH123: next_st.hrdata = {16'h0000, next_st.ch123};
                    `AIMS_OFS_CH0: next_st.hrdata = {16'h0000, next_st.ch0};
                    `AIMS_OFS_SCAN: next_st.hrdata = {16'h0000, next_st.scan};
                    `AIMS_OFS_PORT: next_st.hrdata = {16'h0000, next_st.port_cfg};
                    `AIMS_OFS_CTRL: next_st.hrdata = {16'h0000, next_st.ctrl};
                    `AIMS_OFS_STAT: next_st.hrdata = {26'h0000000, next_st.scan_ptr, next_st.slot_b, 1'b0};
                    default: next_st.hrdata = 32'h00000000;
                endcase
            end
        end
        // Channel 0 selection
        pos = next_st.slot_b ? next_st.ch0[`AIMS_CH0_POS_B] : next_st.ch0[`AIMS_CH0_POS_A];
        scanning = !next_st.slot_b && next_st.ctrl[`AIMS_CTL_SCAN];
        if (scanning) begin
            pos = {1'b0, next_st.scan_ptr};
        end
        next_st.ch0_pos_sel = pos[3:0];
        next_st.ch0_reserved = !scanning && (pos > max_code);
        next_st.ch0_pos_lowref = scanning && !(next_st.scan[next_st.scan_ptr] && pin_exists[next_st.scan_ptr]);
        next_st.ch0_neg_an1 = next_st.slot_b ? next_st.ch0[`AIMS_CH0_NEG_B] : next_st.ch0[`AIMS_CH0_NEG_A];
        // Channels 1 to 3 selection, 10-bit mode only
        tneg = next_st.slot_b ? next_st.ch123[`AIMS_TRIO_NEG_B] : next_st.ch123[`AIMS_TRIO_NEG_A];
        next_st.trio_pos_hi = !next_st.ctrl[`AIMS_CTL_WIDE]
            && (next_st.slot_b ? next_st.ch123[`AIMS_TRIO_POS_B] : next_st.ch123[`AIMS_TRIO_POS_A]);
        next_st.trio_neg_an678 = !next_st.ctrl[`AIMS_CTL_WIDE] && large_part && (tneg == `AIMS_NEG_AN678);
        next_st.trio_reserved = next_st.ctrl[`AIMS_CTL_WIDE] || (tneg == `AIMS_NEG_RSVD)
            || (!large_part && (tneg == `AIMS_NEG_AN678));
        // Port pins
        for (int i = 0; i < 9; i++) begin
            if (!pin_exists[i]) begin
                next_st.port_read_en[i] = 1'b0;
                next_st.mux_ground[i] = 1'b0;
            end else if (next_st.ctrl[`AIMS_CTL_DIS]) begin
                next_st.port_read_en[i] = 1'b1;
                next_st.mux_ground[i] = 1'b1;
            end else begin
                next_st.port_read_en[i] = next_st.port_cfg[i];
                next_st.mux_ground[i] = next_st.port_cfg[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hrdata = st.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ch0_pos_sel = st.ch0_pos_sel;
    assign ch0_pos_lowref = st.ch0_pos_lowref;
    assign ch0_neg_an1 = st.ch0_neg_an1;
    assign ch0_reserved = st.ch0_reserved;
    assign trio_pos_hi = st.trio_pos_hi;
    assign trio_neg_an678 = st.trio_neg_an678;
    assign trio_reserved = st.trio_reserved;
    assign slot_b = st.slot_b;
    assign port_read_en = st.port_read_en;
    assign mux_ground = st.mux_ground;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_port_write;
        hsel && htrans[1] && hready && hwrite && (haddr[4:0] == `AIMS_OFS_PORT);
    endsequence

    sequence s_scan_write;
        hsel && htrans[1] && hready && hwrite && (haddr[4:0] == `AIMS_OFS_SCAN);
    endsequence

    sequence s_slot_a_conv;
        conv_done && !st.slot_b && st.ctrl[`AIMS_CTL_SCAN] && (st.scan[8:0] != 9'h000)
        && !(st.ph_wr && (st.ph_addr == `AIMS_OFS_SCAN));
    endsequence

    a_reserved_bits_zero: assert property (
        ((st.ch123 & ~`AIMS_MSK_CH123) == 16'h0000) && ((st.ch0 & ~`AIMS_MSK_CH0) == 16'h0000)
        && ((st.scan & ~`AIMS_MSK_NINE) == 16'h0000) && ((st.port_cfg & ~`AIMS_MSK_NINE) == 16'h0000))
        else $error("Unimplemented register bit is set");

    a_port_write_lands: assert property (
        s_port_write ##1 1'b1 |=> (st.port_cfg == ($past(hwdata[15:0]) & `AIMS_MSK_NINE)))
        else $error("Port configuration write did not land");

    a_scan_write_lands: assert property (
        s_scan_write ##1 1'b1 |=> (st.scan == ($past(hwdata[15:0]) & `AIMS_MSK_NINE)))
        else $error("Scan selection write did not land");

    a_alt_toggle: assert property (
        st.ctrl[`AIMS_CTL_ALT] && conv_done && !(st.ph_wr && st.ph_addr == `AIMS_OFS_CTRL)
        |=> (slot_b != $past(slot_b)))
        else $error("Alternate sample slot did not toggle");

    a_alt_off_slot_a: assert property (
        !st.ctrl[`AIMS_CTL_ALT] ##1 !st.ctrl[`AIMS_CTL_ALT] |-> !slot_b)
        else $error("Slot B used without alternate mode");

    a_scan_drives_pos: assert property (
        st.ctrl[`AIMS_CTL_SCAN] && !st.slot_b |-> (ch0_pos_sel == st.scan_ptr) && !ch0_reserved)
        else $error("Scan pointer not on channel 0 positive input");

    a_scan_step_included: assert property (
        s_slot_a_conv ##1 st.ctrl[`AIMS_CTL_SCAN] |-> st.scan[st.scan_ptr])
        else $error("Scan moved to an excluded input");

    a_scan_lowref: assert property (
        st.ctrl[`AIMS_CTL_SCAN] && !st.slot_b && !pin_exists[st.scan_ptr] |-> ch0_pos_lowref)
        else $error("Absent scanned input not converted as low reference");

    a_disable_digital: assert property (
        st.ctrl[`AIMS_CTL_DIS] |-> ((port_read_en & mux_ground) == pin_exists))
        else $error("Disabled converter left a shared pin analog");

    a_trio_wide_off: assert property (
        st.ctrl[`AIMS_CTL_WIDE] |-> trio_reserved && !trio_pos_hi && !trio_neg_an678)
        else $error("Trio selection active in 12-bit mode");

    a_absent_pin_quiet: assert property (
        ((port_read_en | mux_ground) & ~pin_exists) == 9'h000)
        else $error("Absent input pin affected");

    a_ch0_code_range: assert property (
        !st.slot_b && !st.ctrl[`AIMS_CTL_SCAN] |-> (ch0_reserved == (st.ch0[`AIMS_CH0_POS_A] > max_code)))
        else $error("Channel 0 code range flag wrong");

    a_ch0_pos_slot: assert property (
        st.slot_b |-> (ch0_pos_sel == 4'(st.ch0[`AIMS_CH0_POS_B]))
        && (ch0_reserved == (st.ch0[`AIMS_CH0_POS_B] > max_code)))
        else $error("Slot B channel 0 selection wrong");

    a_ch0_neg_select: assert property (
        ch0_neg_an1 == (st.slot_b ? st.ch0[`AIMS_CH0_NEG_B] : st.ch0[`AIMS_CH0_NEG_A]))
        else $error("Channel 0 negative select wrong");

    a_trio_neg_part: assert property (
        trio_neg_an678 |-> large_part && !st.ctrl[`AIMS_CTL_WIDE] && !trio_reserved)
        else $error("Trio negative inputs used where not allowed");

    a_trio_rsv_code: assert property (
        ((st.slot_b ? st.ch123[`AIMS_TRIO_NEG_B] : st.ch123[`AIMS_TRIO_NEG_A]) == `AIMS_NEG_RSVD) |-> trio_reserved)
        else $error("Reserved trio negative code not flagged");

    a_trio_pos_select: assert property (
        !st.ctrl[`AIMS_CTL_WIDE]
        |-> (trio_pos_hi == (st.slot_b ? st.ch123[`AIMS_TRIO_POS_B] : st.ch123[`AIMS_TRIO_POS_A])))
        else $error("Trio positive select wrong");

    a_port_follows_cfg: assert property (
        !st.ctrl[`AIMS_CTL_DIS] |-> (port_read_en == (st.port_cfg[8:0] & pin_exists))
        && (mux_ground == (st.port_cfg[8:0] & pin_exists)))
        else $error("Port pin mode does not follow configuration");

    a_slot_hold: assert property (
        st.ctrl[`AIMS_CTL_ALT] && !conv_done |=> $stable(slot_b))
        else $error("Sample slot changed without a conversion");

    a_scan_ptr_hold: assert property (
        st.ctrl[`AIMS_CTL_SCAN] && st.scan[st.scan_ptr] && !(conv_done && !st.slot_b) |=> $stable(st.scan_ptr))
        else $error("Scan pointer moved without a slot A conversion");

endmodule

`default_nettype wire

/* File: include/aims_consts.svh */
// Purpose: Addresses, field positions, masks and sizes of the ADC input selection block
// Assumes: One 32-bit AHB-Lite word per register
// Notes:   Definitions only
`ifndef AIMS_CONSTS_SVH
`define AIMS_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AIMS_OFS_CH123 5'h00
`define AIMS_OFS_CH0   5'h04
`define AIMS_OFS_SCAN  5'h08
`define AIMS_OFS_PORT  5'h0C
`define AIMS_OFS_CTRL  5'h10
`define AIMS_OFS_STAT  5'h14

// ----------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------
`define AIMS_MSK_CH123 16'h0707
`define AIMS_MSK_CH0   16'h9F9F
`define AIMS_MSK_NINE  16'h01FF
`define AIMS_MSK_CTRL  16'h000F
`define AIMS_RST_REG   16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AIMS_TRIO_POS_A 0
`define AIMS_TRIO_NEG_A 2:1
`define AIMS_TRIO_POS_B 8
`define AIMS_TRIO_NEG_B 10:9
`define AIMS_CH0_POS_A  4:0
`define AIMS_CH0_NEG_A  7
`define AIMS_CH0_POS_B  12:8
`define AIMS_CH0_NEG_B  15
`define AIMS_CTL_WIDE   0
`define AIMS_CTL_ALT    1
`define AIMS_CTL_SCAN   2
`define AIMS_CTL_DIS    3

// ----------------------------------------------------------------
// Codes and part sizes
// ----------------------------------------------------------------
`define AIMS_NEG_AN678   2'h2
`define AIMS_NEG_RSVD    2'h3
`define AIMS_PINS_LARGE  4'h9
`define AIMS_PINS_SMALL  4'h6
`define AIMS_MAXC_LARGE  5'h08
`define AIMS_MAXC_SMALL  5'h05
`define AIMS_PTR_NONE    4'hF

`endif

/* File: include/aims_pkg.sv */
// Purpose: Types of the ADC input selection block
// Assumes: Constants come from aims_consts.svh
// Notes:   All block state lives in one packed struct
`default_nettype none

package aims_pkg;

    // ----------------------------------------------------------------
    // Block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        ph_wr;
        logic [4:0]  ph_addr;
        logic [15:0] ch123;
        logic [15:0] ch0;
        logic [15:0] scan;
        logic [15:0] port_cfg;
        logic [15:0] ctrl;
        logic        slot_b;
        logic [3:0]  scan_ptr;
        logic [31:0] hrdata;
        logic [3:0]  ch0_pos_sel;
        logic        ch0_pos_lowref;
        logic        ch0_neg_an1;
        logic        ch0_reserved;
        logic        trio_pos_hi;
        logic        trio_neg_an678;
        logic        trio_reserved;
        logic [8:0]  port_read_en;
        logic [8:0]  mux_ground;
    } aims_state_s;

endpackage

`default_nettype wire

/* File: testbench/aims_conv_model.sv */
// Purpose: Converter sequencer stand-in that issues conversion-done pulses
// Assumes: go is a one-cycle request carrying a count and a spacing
// Notes:   gap 0 gives back-to-back pulses
`default_nettype none

module aims_conv_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request from bench
    input wire logic go,
    input wire logic [7:0] n_req,
    input wire logic [3:0] gap,
    // Converter side
    output logic conv_done,
    output logic busy
);
    logic [7:0] left;
    logic [3:0] wait_c;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left <= 8'h00;
            wait_c <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (go) begin
                left <= n_req;
                wait_c <= gap;
            end else if (left != 8'h00) begin
                if (wait_c != 4'h0) begin
                    wait_c <= wait_c - 4'h1;
                end else begin
                    conv_done <= 1'b1;
                    left <= left - 8'h01;
                    wait_c <= gap;
                end
            end
        end
    end

    assign busy = (left != 8'h00) || go;
endmodule

`default_nettype wire

/* File: testbench/tb_adc_input_mux_select.sv */
// Purpose: Self-checking bench for the ADC input selection block
// Assumes: Large and small parts side by side, zero-wait AHB-Lite slave
// Notes:   Conversions come from the converter model
`include "aims_consts.svh"
`default_nettype none

module tb_adc_input_mux_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] n_req = 8'h00;
    logic [3:0] gap = 4'h0, ch0_pos_sel;
    logic hreadyout, hresp, conv_done, busy, ch0_pos_lowref, ch0_neg_an1, ch0_reserved;
    logic trio_pos_hi, trio_neg_an678, trio_reserved, slot_b;
    logic [8:0] port_read_en, mux_ground;
    logic s_reserved, s_neg678, s_trio_rsv, s_lowref;
    logic [8:0] s_read_en, s_ground;
    int failures = 0, checks_done = 0;

    always #2 hclk = ~hclk;

    aims_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done), .ch0_pos_sel(ch0_pos_sel),
        .ch0_pos_lowref(ch0_pos_lowref), .ch0_neg_an1(ch0_neg_an1), .ch0_reserved(ch0_reserved),
        .trio_pos_hi(trio_pos_hi), .trio_neg_an678(trio_neg_an678), .trio_reserved(trio_reserved),
        .slot_b(slot_b), .port_read_en(port_read_en), .mux_ground(mux_ground));

    aims_conv_model model (.hclk(hclk), .hresetn(hresetn), .go(go), .n_req(n_req), .gap(gap),
        .conv_done(conv_done), .busy(busy));

    aims_top #(.large_part(1'b0)) uut_small (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(),
        .hreadyout(), .hresp(), .conv_done(conv_done), .ch0_pos_sel(), .ch0_pos_lowref(s_lowref),
        .ch0_neg_an1(), .ch0_reserved(s_reserved), .trio_pos_hi(), .trio_neg_an678(s_neg678),
        .trio_reserved(s_trio_rsv), .slot_b(), .port_read_en(s_read_en), .mux_ground(s_ground));

    // ----------------------------------------------------------------
    // Bus, conversion and compare tasks
    // ----------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge hclk);
        #1;
    endtask

    task automatic check_out(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_reg(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check_out("hresp", 32'h0, 32'(hresp));
        checks_done++;
        if (rd !== exp) begin
            failures++;
            $display("mismatch register %h expected %h seen %h", a, exp, rd);
        end
    endtask

    task automatic convert(input logic [7:0] n, input logic [3:0] g);
        @(posedge hclk);
        go <= 1'b1;
        n_req <= n;
        gap <= g;
        @(posedge hclk);
        go <= 1'b0;
        do @(posedge hclk); while (busy === 1'b1);
        settle();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        for (int i = 0; i < 5; i++) check_reg(32'(4 * i), 32'h0);
        check_out("port_read_en", 32'h0, 32'(port_read_en));
        check_out("ch0_pos_sel", 32'h0, 32'(ch0_pos_sel));
        $display("test reset done");
    endtask

    task automatic test_masks();
        logic [31:0] msk [5];
        msk = '{32'(`AIMS_MSK_CH123), 32'(`AIMS_MSK_CH0), 32'h1FF, 32'h1FF, 32'hF};
        for (int i = 0; i < 5; i++) ahb(1'b1, 32'(4 * i), 32'hFFFFFFFF);
        ahb(1'b1, 32'h1C, 32'hFFFFFFFF);
        for (int i = 0; i < 5; i++) check_reg(32'(4 * i), msk[i]);
        check_reg(32'h1C, 32'h0);
        for (int i = 0; i < 5; i++) ahb(1'b1, 32'(4 * i), 32'h0);
        $display("test masks done");
    endtask

    task automatic test_trio();
        logic [2:0] c;
        for (int w = 0; w < 2; w++) begin
            ahb(1'b1, `AIMS_OFS_CTRL, 32'(w));
            for (int i = 0; i < 8; i++) begin
                c = 3'(i);
                ahb(1'b1, `AIMS_OFS_CH123, {21'h0, ~c, 5'h0, c});
                settle();
                check_out("trio_pos_hi", 32'(c[0] & (w == 0)), 32'(trio_pos_hi));
                check_out("trio_neg_an678", 32'(c[2:1] == 2'h2 && w == 0), 32'(trio_neg_an678));
                check_out("trio_reserved", 32'(c[2:1] == 2'h3 || w == 1), 32'(trio_reserved));
                check_out("small trio_neg_an678", 32'h0, 32'(s_neg678));
                check_out("small trio_reserved", 32'(c[2] || w == 1), 32'(s_trio_rsv));
            end
        end
        ahb(1'b1, `AIMS_OFS_CTRL, 32'h0);
        $display("test trio done");
    endtask

    task automatic test_ch0();
        for (int i = 0; i < 10; i++) begin
            ahb(1'b1, `AIMS_OFS_CH0, 32'((i[0] << 7) | i | 32'h1F00));
            settle();
            if (i < 9) check_out("ch0_pos_sel", 32'(i), 32'(ch0_pos_sel));
            check_out("ch0_reserved", 32'(i > 8), 32'(ch0_reserved));
            check_out("small ch0_reserved", 32'(i > 5), 32'(s_reserved));
            check_out("ch0_neg_an1", 32'(i[0]), 32'(ch0_neg_an1));
        end
        $display("test ch0 done");
    endtask

    task automatic test_port();
        ahb(1'b1, `AIMS_OFS_PORT, 32'h0A5);
        settle();
        check_out("port_read_en", 32'h0A5, 32'(port_read_en));
        check_out("mux_ground", 32'h0A5, 32'(mux_ground));
        check_out("small port_read_en", 32'h025, 32'(s_read_en));
        check_out("small mux_ground", 32'h025, 32'(s_ground));
        ahb(1'b1, `AIMS_OFS_CTRL, 32'h8);
        settle();
        check_out("port_read_en", 32'h1FF, 32'(port_read_en));
        check_out("mux_ground", 32'h1FF, 32'(mux_ground));
        check_out("small port_read_en", 32'h03F, 32'(s_read_en));
        check_out("small mux_ground", 32'h03F, 32'(s_ground));
        ahb(1'b1, `AIMS_OFS_CTRL, 32'h0);
        $display("test port done");
    endtask

    task automatic test_alt();
        ahb(1'b1, `AIMS_OFS_CH0, 32'h8702);
        ahb(1'b1, `AIMS_OFS_CTRL, 32'h2);
        settle();
        check_out("ch0_pos_sel", 32'h2, 32'(ch0_pos_sel));
        convert(8'h01, 4'h3);
        check_out("slot_b", 32'h1, 32'(slot_b));
        check_out("ch0_pos_sel", 32'h7, 32'(ch0_pos_sel));
        check_out("ch0_neg_an1", 32'h1, 32'(ch0_neg_an1));
        check_reg(32'(`AIMS_OFS_STAT), 32'h2);
        convert(8'h03, 4'h0);
        check_out("slot_b", 32'h0, 32'(slot_b));
        check_out("ch0_pos_sel", 32'h2, 32'(ch0_pos_sel));
        $display("test alternate done");
    endtask

    task automatic test_scan();
        logic [3:0] seq [4];
        seq = '{4'h1, 4'h4, 4'h8, 4'h1};
        ahb(1'b1, `AIMS_OFS_CH0, 32'h0006);
        ahb(1'b1, `AIMS_OFS_SCAN, 32'h112);
        ahb(1'b1, `AIMS_OFS_CTRL, 32'h4);
        settle();
        for (int i = 0; i < 4; i++) begin
            check_out("scan ch0_pos_sel", 32'(seq[i]), 32'(ch0_pos_sel));
            check_out("ch0_pos_lowref", 32'h0, 32'(ch0_pos_lowref));
            check_out("small lowref", 32'(seq[i] == 4'h8), 32'(s_lowref));
            convert(8'h01, 4'(i));
        end
        check_reg(32'(`AIMS_OFS_STAT), 32'h10);
        ahb(1'b1, `AIMS_OFS_SCAN, 32'h0);
        settle();
        check_out("ch0_pos_lowref", 32'h1, 32'(ch0_pos_lowref));
        check_out("small lowref", 32'h1, 32'(s_lowref));
        $display("test scan done");
    endtask

    task automatic test_rereset();
        ahb(1'b1, 32'(`AIMS_OFS_PORT), 32'h1FF);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check_reg(32'(`AIMS_OFS_PORT), 32'h0);
        check_out("port_read_en", 32'h0, 32'(port_read_en));
        $display("test reset again done");
    endtask

    // ----------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset();
        test_masks();
        test_trio();
        test_ch0();
        test_port();
        test_alt();
        test_scan();
        test_rereset();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        finish_test();
    end
endmodule

`default_nettype wire
